// ---- dv/dqw_asserts.sv ----
// checker on the link between controller end and recognizer end
// assumes instantiation beside the link interface, all on pclk
`timescale 1ns/1ps
module dqw_asserts (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire dqw_pkg::dqw_addr_t login_input_bus,
  input wire logic               login_load,
  input wire logic               sample_clk_en,
  input wire dqw_pkg::dqw_byte_t local_write_bus,
  input wire logic               ram_a_write_strobe_n,
  input wire logic               ram_b_write_strobe_n,
  input wire logic               ram_c_write_strobe_n,
  input wire logic               ram_c_write_strobe_alt_n,
  input wire logic [2:0]         output_invert_select,
  input wire logic               mem_read_flag,
  input wire logic               module_init_n,
  input wire logic               companion_qualifier,
  input wire logic               qual_status_rd_n,
  input wire dqw_pkg::dqw_byte_t qual_status_byte
);
  import dqw_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------
  // link checks
  // ------------
  // single cycle strobe
  strobe_a_pulse_a: assert property ($fell(ram_a_write_strobe_n) |=> ram_a_write_strobe_n)
    else $error("strobe a low longer than one cycle");
  status_low_zero_a: assert property (!qual_status_rd_n |=> qual_status_byte[3:0] == 4'h0)
    else $error("status byte low nibble not zero");
  status_idle_zero_a: assert property (qual_status_rd_n |=> qual_status_byte == 8'h00)
    else $error("status byte shown without read strobe");
  alt_strobe_idle_a: assert property (ram_c_write_strobe_alt_n)
    else $error("alternate c strobe asserted");
  load_with_clock_a: assert property (login_load |-> sample_clk_en)
    else $error("login load without sample edge");
  address_bytes_same_a: assert property (login_load |->
    login_input_bus[23:16] == login_input_bus[7:0] && login_input_bus[15:8] == login_input_bus[7:0])
    else $error("login address bytes differ");
  others_get_ones_a: assert property ((!ram_a_write_strobe_n && !ram_b_write_strobe_n) ||
    (!ram_a_write_strobe_n && !ram_c_write_strobe_n) || (!ram_b_write_strobe_n && !ram_c_write_strobe_n)
    |-> local_write_bus == 8'hFF)
    else $error("joint strobes without all ones");
  c_pattern_copy_a: assert property (!ram_c_write_strobe_n && ram_a_write_strobe_n && ram_b_write_strobe_n
    |-> local_write_bus[7:4] == local_write_bus[3:0])
    else $error("c target pattern not on both nibbles");
  read_gated_clean_a: assert property (!qual_status_rd_n |-> output_invert_select == 3'h0 &&
    !mem_read_flag && module_init_n && companion_qualifier)
    else $error("result gated during readback");
  read_two_cycles_a: assert property ($fell(qual_status_rd_n) |=> !qual_status_rd_n ##1 qual_status_rd_n)
    else $error("read strobe not two cycles");
  read_after_load_a: assert property ($fell(qual_status_rd_n) |-> $past(login_load))
    else $error("read strobe without prior address load");
endmodule : dqw_asserts

// ---- dv/dqw_test.sv ----
// testbench: apb master on the controller end, recognizer end behind the link
// assumes design files compiled first; qual lines watched directly
`timescale 1ns/1ps
`include "dqw_consts.svh"
module dqw_test;
  import dqw_pkg::*;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        is_master;
  wire  [3:0]  qual;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          checks_done;
  int          n_strobe_a;
  int          n_load;
  // entry 5 drops the qualifier while armed; entry 7 re-raises init with no sample edge since
  logic [15:0] ctl_tab [10] = '{16'h0030, 16'h0130, 16'h0230, 16'h0430, 16'h0138, 16'h0010, 16'h0020, 16'h0030,
                                16'h0010, 16'h0110};
  logic [3:0]  exp_tab [10] = '{4'hF, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0};
  logic        mst_tab [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  dqw_if lnk ();
  dqw_ctl u_dqw_ctl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  dqw_dev u_dqw_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk), .is_master(is_master),
    .qual_reset_line(qual[3]), .qual_enable_line(qual[2]), .qual_disable_n_line(qual[1]),
    .qual_any_trigger_line(qual[0]));
  dqw_asserts u_dqw_asserts (.pclk(pclk), .presetn(presetn), .login_input_bus(lnk.login_input_bus),
    .login_load(lnk.login_load), .sample_clk_en(lnk.sample_clk_en), .local_write_bus(lnk.local_write_bus),
    .ram_a_write_strobe_n(lnk.ram_a_write_strobe_n), .ram_b_write_strobe_n(lnk.ram_b_write_strobe_n),
    .ram_c_write_strobe_n(lnk.ram_c_write_strobe_n), .ram_c_write_strobe_alt_n(lnk.ram_c_write_strobe_alt_n),
    .output_invert_select(lnk.output_invert_select), .mem_read_flag(lnk.mem_read_flag),
    .module_init_n(lnk.module_init_n), .companion_qualifier(lnk.companion_qualifier),
    .qual_status_rd_n(lnk.qual_status_rd_n), .qual_status_byte(lnk.qual_status_byte));
  // ------------
  // clock and wire counters
  // ------------
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    if (presetn === 1'b1 && lnk.ram_a_write_strobe_n === 1'b0) n_strobe_a++;
    if (presetn === 1'b1 && lnk.login_load === 1'b1) n_load++;
  end
  // ------------
  // apb master and compares
  // ------------
  // idle cycle at the end keeps psel from being assigned twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t qual lines got %h expected %h", $time, got, exp);
    end
  endtask : chk_nib
  // start, then poll until busy drops; busy rises two cycles after the write
  task automatic run(input logic [31:0] ctrl);
    n_strobe_a = 0;
    n_load = 0;
    apb(1'b1, `DQW_OFS_CTRL, ctrl);
    repeat (3) @(posedge pclk);
    rd = 32'h00000001;
    while (rd[0] === 1'b1) apb(1'b0, `DQW_OFS_STAT, 32'h00000000);
  endtask : run
  task automatic results;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // ------------
  // tests
  // ------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    is_master = 1'b1;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DQW_OFS_CTRL, 32'h00000000);
    chk_word(rd, 32'(`DQW_CTRL_RESET));
    apb(1'b0, `DQW_OFS_STAT, 32'h00000000);
    chk_word(rd, 32'h00000000);
    // unmapped place refused, write ignored
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    chk_word({31'h0, err}, 32'h00000001);
    apb(1'b0, 12'h008, 32'h00000000);
    chk_word({rd[30:0], ~err}, 32'h00000000);
    // power-up limit: five entries, nine passes, fill and read
    run(32'h00000015);
    chk_word(rd & 32'h00000007, 32'h00000002);
    chk_word(32'(n_load), 32'h0000005A);
    chk_word(32'(n_strobe_a), 32'h0000002D);
    // full run over every entry
    run(32'h00000011);
    chk_word(rd & 32'h00000007, 32'h00000002);
    chk_word(32'(n_load), 32'h00001200);
    chk_word(32'(n_strobe_a), 32'h00000900);
    // idle fill with ones, then result gating table
    run(32'h00000013);
    chk_word(32'(n_strobe_a), 32'h00000100);
    for (int i = 0; i < 10; i++) begin
      is_master <= mst_tab[i];
      apb(1'b1, `DQW_OFS_CTRL, {16'h0000, ctl_tab[i]});
      repeat (3) @(posedge pclk);
      chk_nib(qual, exp_tab[i]);
    end
    results();
  end
  // about 17k cycles expected; cut off well beyond
  initial begin
    #(60000 * 50);
    n_errors++;
    results();
  end
endmodule : dqw_test

// ---- hdl/dqw_consts.svh ----
// constants for the data qualifier word recognizer and its controller
// assumes inclusion by bare name from every file that needs them
`ifndef DQW_CONSTS_SVH
`define DQW_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets of the controller
// ----------------------------------------------------------------
`define DQW_OFS_CTRL    12'h000
`define DQW_OFS_STAT    12'h004

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DQW_CTRL_START  0
`define DQW_CTRL_IDLE   1
`define DQW_CTRL_PWRUP  2
`define DQW_CTRL_MEMRD  3
`define DQW_CTRL_INIT_N 4
`define DQW_CTRL_COMP   5
`define DQW_CTRL_TN_LO  8
`define DQW_CTRL_TN_HI  10

// ----------------------------------------------------------------
// test patterns, fill values and limits
// ----------------------------------------------------------------
`define DQW_PAT_0       4'hA
`define DQW_PAT_1       4'h1
`define DQW_PAT_2       4'hC
`define DQW_ALL_ONES    8'hFF
`define DQW_LAST_PWRUP  8'h04
`define DQW_LAST_FULL   8'hFF
`define DQW_LAST_IDX    2'h2
`define DQW_CTRL_RESET  16'h0010

`endif

// ---- hdl/dqw_ctl.sv ----
// instrument controller end: APB registers and the recognizer memory test
// assumes an APB master on pclk and the recognizer end on the same clock
//
// Summary of operation
// - three memories anded into the result
// - each address byte selects one memory
// - 256 four-bit entries per memory
// - memories A,B low nibble, C high
// - value on bus, strobe writes entry
// - address latched from login input bus
// - result inverted unless selects all low
// - memory read flag must stay low
// - master enable needs init, qualifier, edge
// - idle modules filled with all ones
// - status strobe reads result top nibble
// - stored nibble reads back unchanged
// - other memories hold ones during test
// - power-up checks entries 0..4 only
// - fill all, then read ascending, stop
// - three rotated passes per memory, nine
`timescale 1ns/1ps
`include "dqw_consts.svh"
module dqw_ctl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  dqw_if.ctl               lnk
);
  import dqw_pkg::*;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_acc;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [15:0] ctrl_q;
  logic        start_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] stat_word;

  logic        busy_q;
  logic        done_q;
  logic        fail_q;
  logic        fill_only_q;
  dqw_byte_t   addr_q;
  dqw_byte_t   last_q;
  logic [1:0]  ram_q;
  logic [1:0]  pass_q;
  logic [1:0]  pidx_q;
  dqw_byte_t   fail_addr_q;
  dqw_nib_t    exp_q;
  dqw_nib_t    act_q;

  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pready_q && pwrite;
  assign hit_ctrl = (paddr == `DQW_OFS_CTRL);
  assign hit_stat = (paddr == `DQW_OFS_STAT);
  assign stat_word = {8'h00, fail_addr_q, act_q, exp_q, pass_q, ram_q, 1'b0, fail_q, done_q, busy_q};

  // one wait-free access phase; data is fetched during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit_ctrl && !hit_stat;
      if (setup && !pwrite) begin
        prdata_q <= hit_ctrl ? {16'h0000, ctrl_q} : (hit_stat ? stat_word : '0);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `DQW_CTRL_RESET;
      start_q <= 1'b0;
    end else begin
      start_q <= wr_acc && hit_ctrl && pwdata[`DQW_CTRL_START] && !busy_q;
      if (wr_acc && hit_ctrl) begin
        ctrl_q <= pwdata[15:0] & ~(16'h0001 << `DQW_CTRL_START);
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // test sequencer
  // ----------------------------------------------------------------
  dqw_state_t state_q;
  dqw_state_t state_d;
  dqw_nib_t   pat;
  logic       at_last;
  logic       mismatch;
  logic [1:0] pidx_inc;
  logic [1:0] pass_nx;

  // pattern rotates with address and pass
  always_comb begin
    case (pidx_q)
      2'h0:    pat = `DQW_PAT_0;
      2'h1:    pat = `DQW_PAT_1;
      default: pat = `DQW_PAT_2;
    endcase
  end

  assign at_last  = (addr_q == last_q);
  assign pidx_inc = (pidx_q == `DQW_LAST_IDX) ? 2'h0 : pidx_q + 2'h1;
  assign pass_nx  = (pass_q == `DQW_LAST_IDX) ? 2'h0 : pass_q + 2'h1;
  // top nibble compared, low bits masked
  assign mismatch = (lnk.qual_status_byte[7:4] != pat);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:    if (start_q) state_d = ST_LOAD;
      ST_LOAD:    state_d = ST_WR_T;
      ST_WR_T:    state_d = fill_only_q ? (at_last ? ST_IDLE : ST_LOAD) : ST_WR_O;
      ST_WR_O:    state_d = at_last ? ST_RD_LOAD : ST_LOAD;
      ST_RD_LOAD: state_d = ST_RD_STB;
      ST_RD_STB:  state_d = ST_RD_WAIT;
      ST_RD_WAIT: state_d = ST_RD_CMP;
      ST_RD_CMP: begin
        if (mismatch) begin
          state_d = ST_IDLE;
        end else if (!at_last) begin
          state_d = ST_RD_LOAD;
        end else if (pass_q == `DQW_LAST_IDX && ram_q == `DQW_LAST_IDX) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_LOAD;
        end
      end
      default:    state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // power-up run stops at entry 04
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
      last_q <= `DQW_LAST_FULL;
      pidx_q <= '0;
    end else if (state_q == ST_IDLE && start_q) begin
      addr_q <= '0;
      pidx_q <= '0;
      last_q <= ctrl_q[`DQW_CTRL_PWRUP] ? `DQW_LAST_PWRUP : `DQW_LAST_FULL;
    end else if (state_q == ST_WR_O || (state_q == ST_WR_T && fill_only_q)
                 || (state_q == ST_RD_CMP && !mismatch)) begin
      addr_q <= at_last ? 8'h00 : addr_q + 8'h01;
      if (!at_last) begin
        pidx_q <= pidx_inc;
      end else if (state_q == ST_RD_CMP) begin
        pidx_q <= (pass_q == `DQW_LAST_IDX) ? 2'h0 : pass_nx;
      end else begin
        pidx_q <= pass_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_q  <= '0;
      pass_q <= '0;
    end else if (state_q == ST_IDLE && start_q) begin
      ram_q  <= '0;
      pass_q <= '0;
    end else if (state_q == ST_RD_CMP && !mismatch && at_last
                 && !(pass_q == `DQW_LAST_IDX && ram_q == `DQW_LAST_IDX)) begin
      pass_q <= pass_nx;
      if (pass_q == `DQW_LAST_IDX) begin
        ram_q <= ram_q + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      fill_only_q <= 1'b0;
      fail_addr_q <= '0;
      exp_q       <= '0;
      act_q       <= '0;
    end else if (state_q == ST_IDLE && start_q) begin
      busy_q      <= 1'b1;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      fill_only_q <= ctrl_q[`DQW_CTRL_IDLE];
    end else if (state_q != ST_IDLE && state_d == ST_IDLE) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
      if (state_q == ST_RD_CMP && mismatch) begin
        fail_q      <= 1'b1;
        fail_addr_q <= addr_q;
        exp_q       <= pat;
        act_q       <= lnk.qual_status_byte[7:4];
      end
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  dqw_addr_t  login_q;
  logic       load_q;
  dqw_byte_t  lwb_q;
  logic [2:0] wr_n_q;
  logic       rd_n_q;
  logic [2:0] hit;

  for (genvar r = 0; r < 3; r++) begin : g_hit
    assign hit[r] = (ram_q == 2'(r));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      login_q <= '0;
      load_q  <= 1'b0;
      lwb_q   <= `DQW_ALL_ONES;
      wr_n_q  <= 3'h7;
      rd_n_q  <= 1'b1;
    end else begin
      // same byte in all three fields
      login_q <= {3{addr_q}};
      load_q  <= (state_q == ST_LOAD) || (state_q == ST_RD_LOAD);
      lwb_q   <= (state_q == ST_WR_T && !fill_only_q) ? {pat, pat} : `DQW_ALL_ONES;
      // ones into the other two memories
      // each strobe low for one cycle
      wr_n_q  <= ~(({3{state_q == ST_WR_T}} & (hit | {3{fill_only_q}}))
                   | ({3{state_q == ST_WR_O}} & ~hit));
      rd_n_q  <= !(state_q == ST_RD_STB || state_q == ST_RD_WAIT);
    end
  end

  assign lnk.login_input_bus          = login_q;
  assign lnk.login_load               = load_q;
  // sample edge with each address load
  assign lnk.sample_clk_en            = load_q;
  assign lnk.local_write_bus          = lwb_q;
  assign lnk.ram_a_write_strobe_n     = wr_n_q[0];
  assign lnk.ram_b_write_strobe_n     = wr_n_q[1];
  assign lnk.ram_c_write_strobe_n     = wr_n_q[2];
  // alternate strobe unused by this controller
  assign lnk.ram_c_write_strobe_alt_n = 1'b1;
  assign lnk.qual_status_rd_n         = rd_n_q;
  assign lnk.output_invert_select = busy_q ? 3'h0 : ctrl_q[`DQW_CTRL_TN_HI:`DQW_CTRL_TN_LO];
  assign lnk.mem_read_flag        = busy_q ? 1'b0 : ctrl_q[`DQW_CTRL_MEMRD];
  assign lnk.module_init_n        = busy_q ? 1'b1 : ctrl_q[`DQW_CTRL_INIT_N];
  assign lnk.companion_qualifier  = busy_q ? 1'b1 : ctrl_q[`DQW_CTRL_COMP];
endmodule : dqw_ctl

// ---- hdl/dqw_dev.sv ----
// word recognizer end: login latch, three lookup memories, result gating
// assumes the controller end drives the link on the same pclk
`timescale 1ns/1ps
`include "dqw_consts.svh"
module dqw_dev (
  input  wire logic pclk,
  input  wire logic presetn,
  dqw_if.dev        lnk,
  input  wire logic is_master,
  output      logic qual_reset_line,
  output      logic qual_enable_line,
  output      logic qual_disable_n_line,
  output      logic qual_any_trigger_line
);
  import dqw_pkg::*;

  // ----------------------------------------------------------------
  // login registers
  // ----------------------------------------------------------------
  dqw_addr_t latched_acq_address_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_acq_address_q <= '0;
    end else if (lnk.login_load) begin
      latched_acq_address_q <= lnk.login_input_bus;
    end
  end

  // ----------------------------------------------------------------
  // lookup memories
  // ----------------------------------------------------------------
  dqw_nib_t   ram_out [3];
  logic [2:0] we_n;

  assign we_n = {lnk.ram_c_write_strobe_n & lnk.ram_c_write_strobe_alt_n,
                 lnk.ram_b_write_strobe_n, lnk.ram_a_write_strobe_n};

  for (genvar g = 0; g < 3; g++) begin : g_ram
    dqw_ram u_ram (
      .pclk (pclk),
      .we_n (we_n[g]),
      .addr (latched_acq_address_q[g*8 +: 8]),
      .din  ((g == 2) ? lnk.local_write_bus[7:4] : lnk.local_write_bus[3:0]),
      .dout (ram_out[g])
    );
  end

  // ----------------------------------------------------------------
  // result gating
  // ----------------------------------------------------------------
  logic     armed_q;
  logic     enabled;
  dqw_nib_t and_res;
  dqw_nib_t result;

  // needs one sample edge after init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (!lnk.module_init_n) begin
      armed_q <= 1'b0;
    end else if (lnk.sample_clk_en) begin
      armed_q <= 1'b1;
    end
  end

  assign enabled = !is_master || (armed_q && lnk.module_init_n && lnk.companion_qualifier);

  assign and_res = ram_out[0] & ram_out[1] & ram_out[2];

  assign result = ((and_res ^ {4{|lnk.output_invert_select}}) | {4{lnk.mem_read_flag}})
                  & {4{enabled}};

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  dqw_nib_t  qual_q;
  dqw_byte_t status_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_q <= '0;
    end else begin
      qual_q <= result;
    end
  end

  // bit order kept, low nibble zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else if (!lnk.qual_status_rd_n) begin
      status_q <= {result, 4'h0};
    end else begin
      status_q <= '0;
    end
  end

  assign lnk.qual_status_byte  = status_q;
  assign qual_reset_line       = qual_q[3];
  assign qual_enable_line      = qual_q[2];
  assign qual_disable_n_line   = qual_q[1];
  assign qual_any_trigger_line = qual_q[0];
endmodule : dqw_dev

// ---- hdl/dqw_if.sv ----
// link between the instrument controller and the word recognizer
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface dqw_if;
  dqw_pkg::dqw_addr_t login_input_bus;
  logic               login_load;
  logic               sample_clk_en;
  dqw_pkg::dqw_byte_t local_write_bus;
  logic               ram_a_write_strobe_n;
  logic               ram_b_write_strobe_n;
  logic               ram_c_write_strobe_n;
  logic               ram_c_write_strobe_alt_n;
  logic [2:0]         output_invert_select;
  logic               mem_read_flag;
  logic               module_init_n;
  logic               companion_qualifier;
  logic               qual_status_rd_n;
  dqw_pkg::dqw_byte_t qual_status_byte;

  modport ctl (
    output login_input_bus, login_load, sample_clk_en, local_write_bus,
    output ram_a_write_strobe_n, ram_b_write_strobe_n, ram_c_write_strobe_n,
    output ram_c_write_strobe_alt_n, output_invert_select, mem_read_flag,
    output module_init_n, companion_qualifier, qual_status_rd_n,
    input  qual_status_byte
  );
  modport dev (
    input  login_input_bus, login_load, sample_clk_en, local_write_bus,
    input  ram_a_write_strobe_n, ram_b_write_strobe_n, ram_c_write_strobe_n,
    input  ram_c_write_strobe_alt_n, output_invert_select, mem_read_flag,
    input  module_init_n, companion_qualifier, qual_status_rd_n,
    output qual_status_byte
  );
endinterface : dqw_if

// ---- hdl/dqw_pkg.sv ----
// types shared by both ends of the word recognizer link
// assumes nothing beyond a SystemVerilog compiler
package dqw_pkg;
  typedef logic [3:0]  dqw_nib_t;
  typedef logic [7:0]  dqw_byte_t;
  typedef logic [23:0] dqw_addr_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_WR_T, ST_WR_O, ST_RD_LOAD, ST_RD_STB, ST_RD_WAIT, ST_RD_CMP
  } dqw_state_t;
endpackage : dqw_pkg

// ---- hdl/dqw_ram.sv ----
// one 256 x 4 recognizer lookup memory
// assumes a single-cycle active-low write strobe on pclk
`timescale 1ns/1ps
module dqw_ram (
  input  wire logic               pclk,
  input  wire logic               we_n,
  input  wire dqw_pkg::dqw_byte_t addr,
  input  wire dqw_pkg::dqw_nib_t  din,
  output      dqw_pkg::dqw_nib_t  dout
);
  import dqw_pkg::*;

  dqw_nib_t mem [256];

  always_ff @(posedge pclk) begin
    if (!we_n) begin
      mem[addr] <= din;
    end
  end

  assign dout = mem[addr];
endmodule : dqw_ram
